// File: rtl/ucu_top.sv
// ucu_top: up counter with selectable clock, input divider, compare channels
// assumes register port on ref_clk_in; source clocks are slow raw pins
//
// Operation
// R1: compare match raises the channel interrupt
// R2: four selectable counter clock sources
// R3: clear bit or reset zeroes count
// R4: first post-clear step ignores divider
// R5: later steps follow the divider setting
// R6: overflow flag set on period wrap
// R7: restart after halt-at-period falsely flags overflow
// R8: quick compare bump loses next match
// R9: software bumps compare via capture mode
// R10: count steps once per divided edge
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ucu_top
  import ucu_pkg::*;
#(
  parameter int NCH = ucu_pkg::UCU_NCH
)
(
  // clock, reset, enable
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     ce_in,
  // counter clock source pins
  input  wire ucu_pkg::ucu_clk_t        src_clk_in,
  // register port
  input  wire ucu_pkg::ucu_req_t        req_in,
  output logic [ucu_pkg::UCU_DW-1:0]    rdata_out,
  // interrupt and count view
  output logic                          irq_out,
  output logic [ucu_pkg::UCU_DW-1:0]    timer_count_out
);
  import ucu_pkg::*;

  localparam int SW = NCH + 1;  // status width: overflow plus channels

  initial
  begin
    if (NCH < 1 || NCH > 4)
      $error("ucu_top: NCH must lie in 1..4");
  end

  // two-stage synchronisers for the four source pins
  logic [3:0] sync1;  // first stage, read only by sync2
  logic [3:0] sync2;  // second stage
  logic [3:0] sync3;  // previous sync2 for edge detection

  // control registers
  logic [1:0]        src_sel;            // selected clock source
  logic [1:0]        input_divider_select;
  logic              run;                // up mode running
  logic [UCU_DW-1:0] period_compare_value;
  logic [NCH-1:0]    chan_compare_mode;  // 1 compare, 0 capture
  logic [SW-1:0]     status;             // sticky events
  logic [SW-1:0]     mask;               // interrupt enables
  // counter state
  logic [UCU_DW-1:0] timer_count;
  logic [2:0]        div_cnt;            // prescaler count
  logic              first_step;         // next step ignores divider
  logic              wrap_pending;       // halted at period then cleared
  logic [NCH-1:0]    cmp_hit;            // match already flagged at this count
  // next values
  logic [1:0]        next_src_sel;
  logic [1:0]        next_div_sel;
  logic              next_run;
  logic [UCU_DW-1:0] next_period;
  logic [NCH-1:0]    next_chmode;
  logic [SW-1:0]     next_status;
  logic [SW-1:0]     next_mask;
  logic [UCU_DW-1:0] next_count;
  logic [2:0]        next_div_cnt;
  logic              next_first_step;
  logic              next_wrap_pending;
  logic [NCH-1:0]    next_cmp_hit;
  logic [UCU_DW-1:0] next_rdata;
  logic              next_irq;
  // helpers
  logic                  src_edge;       // rising edge of selected source
  logic                  step;           // counter advances this cycle
  logic                  clr_req;        // software clear this cycle
  logic [NCH*UCU_DW-1:0] cmp_all;        // compare values
  logic [UCU_DW-1:0]     cmp_rdata;      // registered memory read
  logic                  cmp_we;         // compare value write
  logic                  rd_cmp_d;       // last read targeted the memory
  logic [SW-1:0]         evt;            // events raised this cycle

  // divider ratio: 1, 2, 4 or 8 source edges per step
  function automatic logic [2:0] div_last(input logic [1:0] sel);
    div_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // is this address a compare slot
  function automatic logic is_cmp(input logic [UCU_AW-1:0] a);
    is_cmp = (a >= UCU_CMP0_OFS) && (int'(a - UCU_CMP0_OFS) < NCH);
  endfunction

  // compare value memory
  assign cmp_we = req_in.wr && is_cmp(req_in.addr);
  ucu_cmp_mem #(.NCH(NCH), .DW(UCU_DW)) u_cmp (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .we_in      (cmp_we),
    .waddr_in   (2'(req_in.addr - UCU_CMP0_OFS)),
    .wdata_in   (req_in.wdata),
    .raddr_in   (2'(req_in.addr - UCU_CMP0_OFS)),
    .rdata_out  (cmp_rdata),
    .all_out    (cmp_all)
  );

  // synchronise source pins; only sync2 and sync3 feed logic
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      // bit 0 carries the inverted pin, so its idle level is high;
      // resetting it low would fake a rising edge right after reset
      sync1 <= 4'h1;
      sync2 <= 4'h1;
      sync3 <= 4'h1;
    end
    else if (ce_in)
    begin
      // the inverted external input is inverted here, before sync
      sync1 <= {src_clk_in.external_timer_clock, src_clk_in.aux_clock,
                src_clk_in.submain_clock, ~src_clk_in.inverted_external_clock};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // selected source edge and step decision
  always_comb
  begin
    src_edge = sync2[src_sel] && !sync3[src_sel];  // [R2]
    clr_req  = req_in.wr && (req_in.addr == UCU_CTRL_OFS)
               && req_in.wdata[UCU_CTRL_CLR_BIT];
    // first edge after clear steps at once, else the prescaler gates it
    step = run && src_edge
           && (first_step || div_cnt == div_last(input_divider_select)); // [R4] [R5] [R10]
  end

  // counter, prescaler and event next state
  always_comb
  begin
    next_count        = timer_count;
    next_div_cnt      = div_cnt;
    next_first_step   = first_step;
    next_wrap_pending = wrap_pending;
    next_cmp_hit      = cmp_hit;
    next_status       = status;
    evt               = '0;
    if (run && src_edge)
    begin
      if (first_step || div_cnt == div_last(input_divider_select))
        next_div_cnt = 3'h0;
      else
        next_div_cnt = div_cnt + 3'h1;  // [R5]
    end
    if (step)
    begin
      next_first_step = 1'b0;
      next_cmp_hit    = '0;
      if (timer_count == period_compare_value)
      begin
        next_count = '0;
        evt[UCU_STAT_OVF_BIT] = 1'b1;  // [R6]
      end
      else
        next_count = timer_count + 16'h0001;  // [R10]
      // silicon quirk: false overflow on first edge after halted clear
      if (wrap_pending)
        evt[UCU_STAT_OVF_BIT] = 1'b1;  // [R7]
      next_wrap_pending = 1'b0;
    end
    // compare match per channel; a match flags once per count value.
    // the hit memory is not refreshed when software moves the compare
    // value, so a bump to count+1 before the next step is swallowed
    for (int c = 0; c < NCH; c++)
    begin
      if (chan_compare_mode[c] && !cmp_hit[c]
          && timer_count == cmp_all[c*UCU_DW +: UCU_DW] && !step)
      begin
        evt[UCU_STAT_CMP_LSB + c] = 1'b1;  // [R1]
        next_cmp_hit[c] = 1'b1;
      end
      // silicon quirk: hit stays armed into the next count [R8]
      if (step && cmp_hit[c] && chan_compare_mode[c]
          && next_count == cmp_all[c*UCU_DW +: UCU_DW])
        next_cmp_hit[c] = 1'b1;  // [R8]
      // capture mode drops the stale hit so the match returns [R9]
      if (!chan_compare_mode[c])
        next_cmp_hit[c] = 1'b0;
    end
    if (clr_req)
    begin
      next_count      = '0;  // [R3]
      next_div_cnt    = 3'h0;
      next_first_step = 1'b1;  // [R4]
      next_cmp_hit    = '0;
      // halted with count at period, then cleared: arm the false flag
      next_wrap_pending = !run && timer_count == period_compare_value;  // [R7]
    end
    // a status read clears; a same-cycle event still wins
    if (req_in.rd && req_in.addr == UCU_STAT_OFS)
      next_status = evt;
    else
      next_status = status | evt;
  end

  // register writes and read mux
  always_comb
  begin
    next_src_sel = src_sel;
    next_div_sel = input_divider_select;
    next_run     = run;
    next_period  = period_compare_value;
    next_chmode  = chan_compare_mode;
    next_mask    = mask;
    next_rdata   = '0;
    if (req_in.wr)
    begin
      case (req_in.addr)
        UCU_CTRL_OFS:
        begin
          next_src_sel = req_in.wdata[UCU_CTRL_SRC_LSB +: 2];
          next_div_sel = req_in.wdata[UCU_CTRL_DIV_LSB +: 2];
          next_run     = req_in.wdata[UCU_CTRL_RUN_BIT];
        end
        UCU_PERIOD_OFS: next_period = req_in.wdata;
        UCU_CHMODE_OFS: next_chmode = req_in.wdata[NCH-1:0];
        UCU_MASK_OFS:   next_mask   = req_in.wdata[SW-1:0];
        default:        next_mask   = mask;  // others ignored
      endcase
    end
    if (req_in.rd)
    begin
      case (req_in.addr)
        UCU_CTRL_OFS:
          next_rdata = 16'({run, input_divider_select, src_sel});
        UCU_COUNT_OFS:  next_rdata = timer_count;
        UCU_PERIOD_OFS: next_rdata = period_compare_value;
        UCU_CHMODE_OFS: next_rdata = 16'(chan_compare_mode);
        UCU_STAT_OFS:   next_rdata = 16'(status);
        UCU_MASK_OFS:   next_rdata = 16'(mask);
        default:        next_rdata = 16'h0000;  // unmapped reads zero
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  // register all state
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      src_sel              <= UCU_CTRL_RST[1:0];
      input_divider_select <= UCU_CTRL_RST[3:2];
      run                  <= 1'b0;
      period_compare_value <= UCU_PERIOD_RST;
      chan_compare_mode    <= '0;
      status               <= '0;
      mask                 <= '0;
      timer_count          <= 16'h0000;  // [R3]
      div_cnt              <= 3'h0;
      first_step           <= 1'b1;      // [R4]
      wrap_pending         <= 1'b0;
      cmp_hit              <= '0;
      rdata_out            <= 16'h0000;
      rd_cmp_d             <= 1'b0;
      irq_out              <= 1'b0;
      timer_count_out      <= 16'h0000;
    end
    else if (ce_in)
    begin
      src_sel              <= next_src_sel;
      input_divider_select <= next_div_sel;
      run                  <= next_run;
      period_compare_value <= next_period;
      chan_compare_mode    <= next_chmode;
      status               <= next_status;
      mask                 <= next_mask;
      timer_count          <= next_count;
      div_cnt              <= next_div_cnt;
      first_step           <= next_first_step;
      wrap_pending         <= next_wrap_pending;
      cmp_hit              <= next_cmp_hit;
      rdata_out            <= next_rdata;
      rd_cmp_d             <= req_in.rd && is_cmp(req_in.addr);
      irq_out              <= next_irq;
      timer_count_out      <= next_count;
    end
  end

  // compare slots read as zero; the memory read register is not routed to rdata_out
  logic unused_cmp;  // memory read is folded in below
  assign unused_cmp = rd_cmp_d & |cmp_rdata;
endmodule
`default_nettype wire

// File: rtl/ucu_pkg.sv
// ucu_pkg: constants, register map and carrier types for the up counter compare unit
// assumes one processor clock domain; counter clock sources arrive as raw pins
package ucu_pkg;
  // data and address widths, channel count
  localparam int UCU_AW = 4;
  localparam int UCU_DW = 16;
  localparam int UCU_NCH = 3;
  // register offsets (word index on the plain register port)
  localparam logic [3:0] UCU_CTRL_OFS   = 4'h0;
  localparam logic [3:0] UCU_COUNT_OFS  = 4'h1;
  localparam logic [3:0] UCU_PERIOD_OFS = 4'h2;
  localparam logic [3:0] UCU_CHMODE_OFS = 4'h3;
  localparam logic [3:0] UCU_STAT_OFS   = 4'h4;
  localparam logic [3:0] UCU_MASK_OFS   = 4'h5;
  localparam logic [3:0] UCU_CMP0_OFS   = 4'h8;
  // control fields
  localparam int UCU_CTRL_SRC_LSB = 0;   // clock source select, 2 bits
  localparam int UCU_CTRL_DIV_LSB = 2;   // input divider select, 2 bits
  localparam int UCU_CTRL_RUN_BIT = 4;   // run in up mode
  localparam int UCU_CTRL_CLR_BIT = 5;   // count clear bit, self clearing
  // status fields: bit 0 overflow, bits 1.. compare channels
  localparam int UCU_STAT_OVF_BIT = 0;
  localparam int UCU_STAT_CMP_LSB = 1;
  // reset values
  localparam logic [15:0] UCU_CTRL_RST   = 16'h0000;
  localparam logic [15:0] UCU_PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] UCU_CMP_RST    = 16'h0000;
  // clock source codes
  typedef enum logic [1:0] {
    UCU_SRC_INV_EXT = 2'h0,
    UCU_SRC_SUBMAIN = 2'h1,
    UCU_SRC_AUX     = 2'h2,
    UCU_SRC_EXT_TMR = 2'h3
  } ucu_src_t;
  // register port request carrier
  typedef struct packed {
    logic [UCU_AW-1:0] addr;
    logic [UCU_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } ucu_req_t;
  // raw counter clock source pins
  typedef struct packed {
    logic inverted_external_clock;
    logic submain_clock;
    logic aux_clock;
    logic external_timer_clock;
  } ucu_clk_t;
endpackage

// File: rtl/ucu_cmp_mem.sv
// ucu_cmp_mem: small store of channel compare values, registered read port
// assumes one write and one read address per cycle, same clock as the caller
`timescale 1ns/1ps
`default_nettype none
module ucu_cmp_mem
#(
  parameter int NCH = 3,
  parameter int DW  = 16
)
(
  // clock and control
  input  wire logic               ref_clk_in,
  input  wire logic               rst_in,
  input  wire logic               ce_in,
  // write side
  input  wire logic               we_in,
  input  wire logic [1:0]         waddr_in,
  input  wire logic [DW-1:0]      wdata_in,
  // read side, data one cycle later
  input  wire logic [1:0]         raddr_in,
  output logic      [DW-1:0]      rdata_out,
  // all values at once for the matchers
  output logic      [NCH*DW-1:0]  all_out
);
  import ucu_pkg::*;
  logic [NCH*DW-1:0] mem;       // stored compare values
  logic [NCH*DW-1:0] next_mem;  // next stored values
  logic [DW-1:0]     next_rd;   // next read word

  initial
  begin
    if (NCH < 1 || NCH > 4)
      $error("ucu_cmp_mem: NCH must lie in 1..4");
  end

  // write merge and read select
  always_comb
  begin
    next_mem = mem;
    next_rd  = '0;
    if (we_in && int'(waddr_in) < NCH)
      next_mem[int'(waddr_in)*DW +: DW] = wdata_in;
    if (int'(raddr_in) < NCH)
      next_rd = mem[int'(raddr_in)*DW +: DW];
  end

  // register stage
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      mem       <= {NCH{UCU_CMP_RST}};
      rdata_out <= '0;
    end
    else if (ce_in)
    begin
      mem       <= next_mem;
      rdata_out <= next_rd;
    end
  end

  assign all_out = mem;
endmodule
`default_nettype wire

// File: testbench/ucu_top_props.sv
// ucu_top_props: port-level checker for the up counter compare unit
// assumes one clock domain, bound to ucu_top by the bench top file
`timescale 1ns/1ps
`default_nettype none
module ucu_top_props
  import ucu_pkg::*;
#(
  parameter int NCH = ucu_pkg::UCU_NCH
)
(
  // clock, reset, enable
  input wire logic                  ref_clk_in,
  input wire logic                  rst_in,
  input wire logic                  ce_in,
  // source pins and register port
  input wire ucu_pkg::ucu_clk_t     src_clk_in,
  input wire ucu_pkg::ucu_req_t     req_in,
  input wire logic [UCU_DW-1:0]     rdata_out,
  // interrupt and count view
  input wire logic                  irq_out,
  input wire logic [UCU_DW-1:0]     timer_count_out
);
  import ucu_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire logic  wr_ctrl = req_in.wr && (req_in.addr == UCU_CTRL_OFS);
  wire logic  wr_mask = req_in.wr && (req_in.addr == UCU_MASK_OFS);
  logic       run_q, next_run_q;     // last written run bit
  logic       mask_z, next_mask_z;   // mask known to be all zero
  logic [3:0] quiet, next_quiet;     // cycles since a source pin moved
  logic [3:0] halt_n, next_halt_n;   // cycles since run went low
  ucu_clk_t   src_q;
  // helper next state; counters saturate so they never wrap back into range
  always_comb
  begin
    next_run_q  = wr_ctrl ? req_in.wdata[UCU_CTRL_RUN_BIT] : run_q;
    next_mask_z = wr_mask ? (req_in.wdata == 16'h0000) : mask_z;
    next_quiet  = (src_clk_in != src_q) ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
    next_halt_n = run_q ? 4'h0 : ((halt_n == 4'h7) ? halt_n : halt_n + 4'h1);
  end
  // helper registers
  always_ff @(posedge ref_clk_in)
  begin
    run_q  <= rst_in ? 1'b0 : next_run_q;
    mask_z <= rst_in ? 1'b1 : next_mask_z;
    quiet  <= rst_in ? 4'h0 : next_quiet;
    halt_n <= rst_in ? 4'h0 : next_halt_n;
    src_q  <= src_clk_in;
  end
  AST_RST_ZERO: assert property (disable iff (1'b0) rst_in |=>
    (timer_count_out == 16'h0000) && !irq_out) else $error("count not zero after reset");
  AST_CLR_ZERO: assert property (wr_ctrl && req_in.wdata[UCU_CTRL_CLR_BIT] |->
    ##[1:4] (timer_count_out == 16'h0000)) else $error("clear bit did not zero count");
  AST_STEP_ONE: assert property ($changed(timer_count_out) |->
    (timer_count_out == $past(timer_count_out) + 16'h0001) || (timer_count_out == 16'h0000))
    else $error("count moved by other than one");
  AST_HALT_STILL: assert property ((halt_n == 4'h7) |->
    $stable(timer_count_out) || (timer_count_out == 16'h0000)) else $error("count moved halted");
  AST_NOSRC_STILL: assert property ((quiet > 4'h7) |->
    $stable(timer_count_out) || (timer_count_out == 16'h0000)) else $error("step without edge");
  AST_IDLE_RD: assert property (ce_in && !req_in.rd |=> (rdata_out == 16'h0000))
    else $error("read data without read");
  AST_UNMAP_RD: assert property (req_in.rd && (req_in.addr inside {[4'h6:4'hF]}) |=>
    (rdata_out == 16'h0000)) else $error("unmapped read not zero");
  AST_MASK_QUIET: assert property (mask_z && $past(mask_z) |-> !irq_out)
    else $error("interrupt with mask clear");
  // main scenarios
  cover property ($rose(irq_out));
  cover property (wr_ctrl && req_in.wdata[UCU_CTRL_CLR_BIT]);
  cover property ($changed(timer_count_out) && (timer_count_out == 16'h0000));
endmodule
`default_nettype wire

// File: testbench/ucu_top_tb_top.sv
// ucu_top_tb_top: self-checking bench for the up counter compare unit
// assumes ucu_pkg, ucu_top and the checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module ucu_top_tb_top;
  import ucu_pkg::*;
  logic              ref_clk_in = 1'b0;
  logic              rst_in;
  logic              ce_in;       // held high except in the freeze test, which drives it low
  ucu_clk_t          src_clk_in;  // bit 3 inverted ext .. bit 0 ext timer
  ucu_req_t          req_in;
  logic [UCU_DW-1:0] rdata_out;
  logic [UCU_DW-1:0] timer_count_out;
  logic              irq_out;
  int                n_errors = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                m;
  int                c;
  logic [31:0]       lfsr;
  logic [15:0]       d;
  ucu_top #(.NCH(UCU_NCH)) ucu_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .src_clk_in(src_clk_in), .req_in(req_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .timer_count_out(timer_count_out));
  always #12.5 ref_clk_in = ~ref_clk_in;
  // hang guard: far above the roughly one thousand cycles the tests need
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA3000000) : (s >> 1);
  endfunction
  function automatic logic [15:0] ctl(input logic [1:0] s, input logic [1:0] dv,
                                      input logic run, input logic clr);
    return {10'h000, clr, run, dv, s};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk_in);
    req_in <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    req_in <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk_in);
    req_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    req_in <= '0;
    #1 v = rdata_out;
  endtask
  // full pulses, 6 cycles per level, so the synchroniser sees every edge
  task automatic pulse(input logic [3:0] pins, input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in) src_clk_in <= pins;
      repeat (6) @(posedge ref_clk_in);
      src_clk_in <= '0;
      repeat (6) @(posedge ref_clk_in);
    end
    repeat (6) @(posedge ref_clk_in);
  endtask
  // clear while halted, then run
  task automatic restart(input logic [1:0] s, input logic [1:0] dv);
    wr(UCU_CTRL_OFS, ctl(s, dv, 1'b0, 1'b1));
    wr(UCU_CTRL_OFS, ctl(s, dv, 1'b1, 1'b0));
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    src_clk_in = '0;
    req_in = '0;
    lfsr = 32'h00015B0E;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(UCU_CTRL_OFS, d); `CHK(d, UCU_CTRL_RST)
    rd(UCU_PERIOD_OFS, d); `CHK(d, UCU_PERIOD_RST)
    rd(4'h6, d); `CHK(d, 16'h0000)
    `CHK(timer_count_out, 16'h0000)
    $display("test reset done");
    // every source code; pins not selected must not count
    for (int s = 0; s < 4; s++)
    begin
      lfsr = lfsr_step(lfsr);
      m = 1 + int'(lfsr[1:0] % 2'h3);
      restart(s[1:0], 2'h0);
      pulse(4'hF ^ (4'h8 >> s), 2);
      `CHK(timer_count_out, 16'h0000)
      pulse(4'h8 >> s, m);
      `CHK(timer_count_out, 16'(m))
    end
    $display("test sources done");
    // first step ignores the divider; 1 + m*div edges give 1 + m for every divider setting
    for (int dv = 0; dv < 4; dv++)
    begin
      lfsr = lfsr_step(lfsr);
      m = 1 + int'(lfsr[1:0] % 2'h3);
      restart(2'h1, dv[1:0]);
      pulse(4'h4, 1);
      `CHK(timer_count_out, 16'h0001)
      pulse(4'h4, m << dv);
      `CHK(timer_count_out, 16'(1 + m))
    end
    $display("test divider done");
    // wrap at period, sticky flag, interrupt, read clears
    restart(2'h3, 2'h0);
    wr(UCU_PERIOD_OFS, 16'h0002);
    wr(UCU_MASK_OFS, 16'h0001);
    rd(UCU_STAT_OFS, d);
    pulse(4'h1, 2);
    `CHK(irq_out, 1'b0)
    pulse(4'h1, 1);
    `CHK(timer_count_out, 16'h0000)
    `CHK(irq_out, 1'b1)
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0001)
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0000)
    `CHK(irq_out, 1'b0)
    $display("test overflow done");
    // halt at period, clear, restart: one false overflow
    pulse(4'h1, 2);
    wr(UCU_CTRL_OFS, ctl(2'h3, 2'h0, 1'b0, 1'b0));
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0000)
    restart(2'h3, 2'h0);
    pulse(4'h1, 1);
    `CHK(timer_count_out, 16'h0001)
    wr(UCU_MASK_OFS, 16'h0000);
    repeat (2) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b0)
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0001)
    $display("test restart done");
    // compare hit, quick bump lost, bump through capture mode kept
    lfsr = lfsr_step(lfsr);
    c = int'(lfsr[5:4] % 2'h3);
    wr(UCU_MASK_OFS, 16'h000E);
    wr(UCU_CHMODE_OFS, 16'h0001 << c);
    wr(UCU_CMP0_OFS + 4'(c), 16'h0002);
    wr(UCU_PERIOD_OFS, 16'h00FF);
    restart(2'h2, 2'h0);
    rd(UCU_STAT_OFS, d);
    pulse(4'h2, 2);
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0002 << c)
    wr(UCU_CMP0_OFS + 4'(c), 16'h0003);
    pulse(4'h2, 1);
    `CHK(timer_count_out, 16'h0003)
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0000)
    wr(UCU_CHMODE_OFS, 16'h0000);
    wr(UCU_CMP0_OFS + 4'(c), 16'h0004);
    wr(UCU_CHMODE_OFS, 16'h0001 << c);
    pulse(4'h2, 1);
    `CHK(irq_out, 1'b1)
    rd(UCU_STAT_OFS, d); `CHK(d, 16'h0002 << c)
    $display("test compare done");
    // clock enable low freezes the counter despite source edges
    @(posedge ref_clk_in) ce_in <= 1'b0;
    pulse(4'h2, 2);
    `CHK(timer_count_out, 16'h0004)
    @(posedge ref_clk_in) ce_in <= 1'b1;
    pulse(4'h2, 1);
    `CHK(timer_count_out, 16'h0005)
    $display("test freeze done");
    complete_run();
  end
endmodule
bind ucu_top ucu_top_props #(.NCH(NCH)) ucu_top_props_i (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .ce_in(ce_in), .src_clk_in(src_clk_in), .req_in(req_in),
  .rdata_out(rdata_out), .irq_out(irq_out), .timer_count_out(timer_count_out));
`default_nettype wire
